// *** core/pbl_panel.sv ***
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pbl_panel #(
  parameter int FLASH_HALF_CYC = pbl_pkg::FLASH_HALF_CYC
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic nrst, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [31:0] rd_data, // read data, cycle after rd_en
  input wire logic [4:0] button_pin, // raw button contacts
  output logic [4:0] lamp_out, // button lamp drive, high lit
  output logic irq // level interrupt
);

  // ==========================================================
  // decode
  wire hit_cfg = addr == pbl_pkg::OFF_LATCH_CFG;
  wire hit_assign = addr == pbl_pkg::OFF_OVR_ASSIGN;
  wire hit_or = addr == pbl_pkg::OFF_OVR_OR;
  wire hit_and = addr == pbl_pkg::OFF_OVR_AND;
  wire hit_on = addr == pbl_pkg::OFF_LAMP_ON;
  wire hit_flash = addr == pbl_pkg::OFF_LAMP_FLASH;
  wire hit_sep = addr == pbl_pkg::OFF_LAMP_SEP;
  wire hit_ist = addr == pbl_pkg::OFF_IRQ_STATUS;
  wire hit_imask = addr == pbl_pkg::OFF_IRQ_MASK;
  wire [4:0] wr_sel = wr_data[pbl_pkg::SEL_LSB +: 5];
  wire [4:0] wr_val = wr_data[pbl_pkg::VAL_LSB +: 5];

  logic [4:0] button_latch_config;
  logic lamp_separation_flag;
  logic [4:0] lamp_on;
  logic [4:0] lamp_flash;
  logic [9:0] irq_status;
  logic [9:0] irq_mask;
  wire [4:0] button_pressed_status;
  logic [4:0] status_prev;
  logic flash_phase;

  wire pbl_pkg::pbl_ovr_t ovr_kind =
    !wr_en ? pbl_pkg::PBL_OVR_NONE :
    hit_assign ? pbl_pkg::PBL_OVR_ASSIGN :
    hit_or ? pbl_pkg::PBL_OVR_OR :
    hit_and ? pbl_pkg::PBL_OVR_AND : pbl_pkg::PBL_OVR_NONE;

  // ==========================================================
  // per-button state
  genvar gi;
  generate
    for (gi = 0; gi < pbl_pkg::N_BTN; gi++) begin : g_btn
      wire pbl_pkg::pbl_ovr_t kind_i = wr_sel[gi] ? ovr_kind : pbl_pkg::PBL_OVR_NONE;
      // overrides act on the latch whatever the mode; host keeps to alternate
      pbl_button u_button (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin(button_pin[gi]),
        .latch_cfg(button_latch_config[gi]),
        .ovr_kind(kind_i),
        .ovr_val(wr_val[gi]),
        .pressed(button_pressed_status[gi])
      );
    end
  endgenerate

  pbl_blinker #(
    .HALF_CYC(FLASH_HALF_CYC)
  ) u_blinker (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .phase(flash_phase)
  );

  // ==========================================================
  // configuration and lamp override registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      button_latch_config <= pbl_pkg::RST_LATCH_CFG;
      lamp_separation_flag <= pbl_pkg::RST_LAMP_SEP;
      lamp_on <= 5'h00;
      lamp_flash <= 5'h00;
      irq_mask <= pbl_pkg::RST_IRQ_MASK;
    end else if (wr_en) begin
      if (hit_cfg) begin
        button_latch_config <= wr_data[4:0];
      end
      if (hit_sep) begin
        lamp_separation_flag <= wr_data[0];
      end
      if (hit_on) begin
        lamp_on <= (lamp_on & ~wr_sel) | (wr_val & wr_sel);
      end
      if (hit_flash) begin
        lamp_flash <= (lamp_flash & ~wr_sel) | (wr_val & wr_sel);
      end
      if (hit_imask) begin
        irq_mask <= wr_data[9:0];
      end
    end
  end

  // ==========================================================
  // lamp output; flash only blanks a lamp that is on, host orders it so
  wire [4:0] lamp_sep = lamp_on & ~(lamp_flash & {5{~flash_phase}});
  wire [4:0] next_lamp = lamp_separation_flag ? lamp_sep : button_pressed_status;

  // ==========================================================
  // interrupts: set beats a write-one clear in the same cycle
  wire [4:0] rose = button_pressed_status & ~status_prev;
  wire [4:0] fell = ~button_pressed_status & status_prev;
  wire [9:0] ist_clr = (wr_en && hit_ist) ? wr_data[9:0] : 10'h000;
  wire [9:0] next_ist = (irq_status & ~ist_clr) | {fell, rose};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_prev <= 5'h00;
      irq_status <= 10'h000;
      irq <= 1'b0;
      lamp_out <= 5'h00;
    end else begin
      status_prev <= button_pressed_status;
      irq_status <= next_ist;
      irq <= |(next_ist & irq_mask);
      lamp_out <= next_lamp;
    end
  end

  // ==========================================================
  // read path; write-only and unmapped addresses read zero
  wire [31:0] rd_mux =
    hit_cfg ? {27'h0, button_latch_config} :
    (addr == pbl_pkg::OFF_PRESSED) ? {27'h0, button_pressed_status} :
    hit_sep ? {31'h0, lamp_separation_flag} :
    hit_ist ? {22'h0, irq_status} :
    hit_imask ? {22'h0, irq_mask} :
    (addr == pbl_pkg::OFF_LAMP_STATE) ? {27'h0, lamp_out} : 32'h0;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h0;
    end else begin
      rd_data <= rd_en ? rd_mux : 32'h0;
    end
  end

endmodule : pbl_panel
`default_nettype wire

// *** core/pbl_pkg.sv ***
package pbl_pkg;

  // ==========================================================
  // geometry
  localparam int N_BTN = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_LATCH_CFG = 8'h00;
  localparam logic [7:0] OFF_PRESSED = 8'h04;
  localparam logic [7:0] OFF_OVR_ASSIGN = 8'h08;
  localparam logic [7:0] OFF_OVR_OR = 8'h0c;
  localparam logic [7:0] OFF_OVR_AND = 8'h10;
  localparam logic [7:0] OFF_LAMP_ON = 8'h14;
  localparam logic [7:0] OFF_LAMP_FLASH = 8'h18;
  localparam logic [7:0] OFF_LAMP_SEP = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_LAMP_STATE = 8'h28;

  // ==========================================================
  // field layout of write-only per-button commands
  localparam int SEL_LSB = 0;
  localparam int VAL_LSB = 8;
  // irq status: press events low, release events above
  localparam int IRQ_W = 2 * N_BTN;
  localparam int IRQ_REL_LSB = N_BTN;

  // ==========================================================
  // reset values
  localparam logic [4:0] RST_LATCH_CFG = 5'h00;
  localparam logic RST_LAMP_SEP = 1'b0;
  localparam logic [9:0] RST_IRQ_MASK = 10'h000;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    PBL_OVR_NONE,
    PBL_OVR_ASSIGN,
    PBL_OVR_OR,
    PBL_OVR_AND
  } pbl_ovr_t;

endpackage : pbl_pkg

// *** core/pbl_button.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbl_button (
  input wire logic ref_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic pin, // raw button contact, asynchronous
  input wire logic latch_cfg, // 1 alternate, 0 momentary
  input wire pbl_pkg::pbl_ovr_t ovr_kind, // override kind, one cycle
  input wire logic ovr_val, // override value
  output logic pressed // reported pressed status
);

  // ==========================================================
  // synchroniser
  logic sync_a;
  logic sync_b;
  logic pin_prev;
  logic latched;
  logic next_latched;
  logic press_edge;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      pin_prev <= sync_b;
    end
  end

  assign press_edge = sync_b & ~pin_prev;

  // ==========================================================
  // latched state; an override beats a press in the same cycle
  always_comb begin
    next_latched = latched;
    if (latch_cfg && press_edge) begin
      next_latched = ~latched;
    end
    unique case (ovr_kind)
      pbl_pkg::PBL_OVR_NONE: ;
      pbl_pkg::PBL_OVR_ASSIGN: next_latched = ovr_val;
      pbl_pkg::PBL_OVR_OR: next_latched = latched | ovr_val;
      pbl_pkg::PBL_OVR_AND: next_latched = ~(latched & ovr_val);
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      latched <= 1'b0;
    end else begin
      latched <= next_latched;
    end
  end

  assign pressed = latch_cfg ? latched : sync_b;

endmodule : pbl_button
`default_nettype wire

// *** core/pbl_blinker.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbl_blinker #(
  parameter int HALF_CYC = pbl_pkg::FLASH_HALF_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic nrst, // async reset, active low
  output logic phase // flash phase, toggles every half period
);

  // one shared timebase keeps every flashing lamp in step
  logic [31:0] count;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0;
      phase <= 1'b0;
    end else if (count == 32'(HALF_CYC - 1)) begin
      count <= 32'h0;
      phase <= ~phase;
    end else begin
      count <= count + 32'h1;
    end
  end

endmodule : pbl_blinker
`default_nettype wire

// *** tb/pbl_contacts.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbl_contacts (
  input wire logic ref_clk, // clock
  input wire logic [4:0] press, // fingers on buttons
  output logic [4:0] button_pin // contacts
);
  // contacts move off the clock edge, as a real finger would
  // one process drives the contacts; they settle at the first falling edge, inside reset
  always @(negedge ref_clk) button_pin <= press;
endmodule : pbl_contacts
`default_nettype wire

// *** tb/pbl_panel_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbl_props (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic [7:0] addr, // address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [31:0] rd_data, // read data
  input wire logic [4:0] button_pin, // contacts
  input wire logic [4:0] lamp_out, // lamps
  input wire logic irq // interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========
  // shadows
  logic sep;
  logic rv;
  logic [4:0] cfg;
  logic [7:0] ra;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sep <= 1'b0;
      cfg <= 5'h00;
      rv <= 1'b0;
      ra <= 8'h00;
    end else begin
      rv <= rd_en;
      ra <= addr;
      if (wr_en && addr == 8'h1c) sep <= wr_data[0];
      if (wr_en && addr == 8'h00) cfg <= wr_data[4:0];
    end
  end
  // ==========
  // properties
  rd_idle_a: assert property (!rv |-> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  cfg_read_a: assert property (rv && ra == 8'h00 |-> rd_data == {27'h0, cfg})
    else $error("latch config readback wrong");
  sep_read_a: assert property (rv && ra == 8'h1c |-> rd_data == {31'h0, sep})
    else $error("separation flag readback wrong");
  status_read_a: assert property (rv && ra == 8'h04 |-> rd_data[31:5] == 27'h0)
    else $error("status upper bits set");
  ovr_wo_a: assert property (rv && ra inside {8'h08, 8'h0c, 8'h10} |-> rd_data == 32'h0)
    else $error("override control readable");
  lamp_wo_a: assert property (rv && ra inside {8'h14, 8'h18} |-> rd_data == 32'h0)
    else $error("lamp control readable");
  lamp_read_a: assert property (rv && ra == 8'h28 |-> rd_data == {27'h0, $past(lamp_out)})
    else $error("lamp state differs from lamp pins");
  lamp_mirror_a: assert property ((!sep && cfg == 5'h00 && $stable(button_pin))[*6]
    |-> lamp_out == button_pin) else $error("lamp does not follow press");
  cover property (rv && ra == 8'h04 && rd_data[4:0] != 5'h00);
  cover property ($rose(irq));
  cover property (sep && $changed(lamp_out));
endmodule : pbl_props
bind pbl_panel pbl_props u_pbl_props (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .button_pin(button_pin), .lamp_out(lamp_out), .irq(irq));
`default_nettype wire

// *** tb/pbl_panel_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module pbl_panel_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rv = 1'b0;
  logic [4:0] press = 5'h00;
  logic [31:0] rd_data;
  logic [4:0] button_pin;
  logic [4:0] lamp_out;
  logic irq;
  logic [31:0] seed = 32'h86d9;
  logic [31:0] q[$];
  int miscompares = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  pbl_contacts u_pbl_contacts (.ref_clk(ref_clk), .press(press), .button_pin(button_pin));
  pbl_panel #(.FLASH_HALF_CYC(4)) u_pbl_panel (.ref_clk(ref_clk), .nrst(nrst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .button_pin(button_pin), .lamp_out(lamp_out), .irq(irq));
  // ==========
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask : rd
  task automatic ovr(logic [7:0] a, logic [4:0] v);
    wr(a, {19'h0, v, 8'h1f});
  endtask : ovr
  task automatic wait_irq(logic lvl);
    int n = 0;
    while (irq !== lvl && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (irq !== lvl) begin
      miscompares++;
      complete_run();
    end
  endtask : wait_irq
  // read data shows one cycle after the strobe; match it to the oldest note
  always @(posedge ref_clk) begin
    rv <= rd_en;
    if (rv) begin
      chk("rd_data", rd_data, q.pop_front());
    end
  end
  // ==========
  // scenarios
  initial begin : main
    logic [4:0] s;
    logic [4:0] v;
    int n;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'h00, 0);
    rd(8'h1c, 0);
    rd(8'h24, 0);
    rd(8'h08, 0);
    rd(8'h3c, 0);
    s = 5'(xs());
    press <= s;
    repeat (6) @(posedge ref_clk);
    rd(8'h04, {27'h0, s});
    rd(8'h28, {27'h0, s});
    press <= 5'h00;
    wr(8'h00, 32'h1f);
    rd(8'h00, 32'h1f);
    for (n = 0; n < 9; n++) begin
      v = 5'(xs());
      case (n % 3)
        0: s = v;
        1: s = s | v;
        default: s = ~(s & v);
      endcase
      ovr(8'h08 + 8'(4 * (n % 3)), v);
      rd(8'h04, {27'h0, s});
    end
    wr(8'h04, 32'h1f);
    rd(8'h04, {27'h0, s});
    ovr(8'h08, 5'h00);
    wr(8'h20, 32'h3ff);
    wr(8'h24, 32'h3ff);
    press <= 5'h04;
    wait_irq(1'b1);
    press <= 5'h00;
    rd(8'h20, 32'h4);
    rd(8'h04, 32'h4);
    wr(8'h24, 32'h0);
    wait_irq(1'b0);
    wr(8'h24, 32'h3ff);
    wait_irq(1'b1);
    wr(8'h20, 32'h3ff);
    wait_irq(1'b0);
    wr(8'h00, 32'h0);
    wr(8'h1c, 32'h1);
    rd(8'h1c, 32'h1);
    press <= 5'h0a;
    ovr(8'h14, 5'h15);
    rd(8'h28, 32'h15);
    wr(8'h18, 32'h101);
    repeat (2) @(posedge ref_clk);
    s = 5'h00;
    repeat (16) begin
      @(posedge ref_clk);
      s = s + 5'(lamp_out[0]);
    end
    chk("flash", {27'h0, s}, 32'h8);
    ovr(8'h18, 5'h00);
    repeat (2) @(posedge ref_clk);
    rd(8'h28, 32'h15);
    wr(8'h1c, 32'h0);
    repeat (6) @(posedge ref_clk);
    rd(8'h28, 32'h0a);
    repeat (3) @(posedge ref_clk);
    complete_run();
  end
endmodule : pbl_panel_tb
`default_nettype wire
